// file: hw/lbm_pkg.sv
package lbm_pkg;
  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] ADDR_RAISE_LEVEL = 8'h00;
  localparam logic [7:0] ADDR_CLEAR_LEVEL = 8'h04;
  localparam logic [7:0] ADDR_LEAK_RATE = 8'h08;
  localparam logic [7:0] ADDR_BUCKET_SIZE = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  // Reset values of the software registers.
  localparam logic [7:0] RAISE_LEVEL_RST = 8'h08;
  localparam logic [7:0] CLEAR_LEVEL_RST = 8'h04;
  localparam logic [1:0] LEAK_RATE_RST = 2'h1;
  localparam logic [7:0] BUCKET_SIZE_RST = 8'h08;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  // Field positions.
  localparam int STATUS_ALARM_BIT = 8;
  localparam int IRQ_RAISE_BIT = 0;
  localparam int IRQ_CLEAR_BIT = 1;
  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: hw/lbm_top.sv
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
// How it works
// - Bad or erratic monitoring cycle adds one.
// - Each clean leak period of 1/2/4/8 subtracts one.
// - Leaking down to clear level clears alarm.
// - Clear level: 8-bit read/write, resets to 0x04.
module lbm_top #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mon_tick,
  input wire logic ref_bad,
  output logic alarm,
  output logic irq,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  if (ADDR_W < 8)
  begin : g_chk
    $error("ADDR_W must be at least 8");
  end

  typedef struct packed {
    logic [7:0] acc;
    logic [3:0] leak_cnt;
    logic alarm;
    logic [7:0] raise_level;
    logic [7:0] clear_level;
    logic [1:0] leak_rate;
    logic [7:0] bucket_size;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic irq;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [7:0] w_data;
    logic w_strb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } lbm_state_t;

  lbm_state_t st_reg;
  lbm_state_t st_next;

  // Leak period in monitoring cycles for a two-bit rate code.
  function automatic logic [3:0] lbm_period(input logic [1:0] code);
    lbm_period = 4'h1 << code;
  endfunction

  // Address decode shared by the read path and the write path.
  function automatic logic lbm_mapped(input logic [7:0] a);
    lbm_mapped = (a == lbm_pkg::ADDR_RAISE_LEVEL) || (a == lbm_pkg::ADDR_CLEAR_LEVEL) ||
                 (a == lbm_pkg::ADDR_LEAK_RATE) || (a == lbm_pkg::ADDR_BUCKET_SIZE) ||
                 (a == lbm_pkg::ADDR_STATUS) || (a == lbm_pkg::ADDR_IRQ_STATUS) ||
                 (a == lbm_pkg::ADDR_IRQ_MASK);
  endfunction

  logic do_write;
  logic [1:0] ev;

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the bucket, the alarm and the register slave.
  always_comb
  begin
    st_next = st_reg;
    ev = 2'h0;
    // Bucket: a bad cycle adds and restarts the leak timer, a clean cycle counts toward a leak.
    if (mon_tick)
    begin
      if (ref_bad)
      begin
        st_next.leak_cnt = 4'h0;
        if (st_reg.acc < st_reg.bucket_size)
        begin
          st_next.acc = st_reg.acc + 8'h01;
        end
      end
      else if (st_reg.leak_cnt + 4'h1 >= lbm_period(st_reg.leak_rate))
      begin
        st_next.leak_cnt = 4'h0;
        if (st_reg.acc != 8'h00)
        begin
          st_next.acc = st_reg.acc - 8'h01;
        end
      end
      else
      begin
        st_next.leak_cnt = st_reg.leak_cnt + 4'h1;
      end
    end
    // Raise has priority so a misprogrammed clear level above raise level cannot chatter.
    if (!st_reg.alarm && st_reg.acc >= st_reg.raise_level)
    begin
      st_next.alarm = 1'b1;
      ev[lbm_pkg::IRQ_RAISE_BIT] = 1'b1;
    end
    else if (st_reg.alarm && st_reg.acc <= st_reg.clear_level && st_reg.acc < st_reg.raise_level)
    begin
      st_next.alarm = 1'b0;
      ev[lbm_pkg::IRQ_CLEAR_BIT] = 1'b1;
    end
    // Write channel: address and data are latched independently, in either order.
    if (s_axi_awvalid && st_reg.awready)
    begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && st_reg.wready)
    begin
      st_next.w_have = 1'b1;
      st_next.w_data = s_axi_wdata[7:0];
      st_next.w_strb0 = s_axi_wstrb[0];
    end
    if (st_reg.bvalid && s_axi_bready)
    begin
      st_next.bvalid = 1'b0;
    end
    do_write = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
    if (do_write)
    begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = lbm_mapped(st_reg.aw_addr) ? lbm_pkg::RESP_OKAY : lbm_pkg::RESP_SLVERR;
      if (st_reg.w_strb0)
      begin
        case (st_reg.aw_addr)
          lbm_pkg::ADDR_RAISE_LEVEL: st_next.raise_level = st_reg.w_data;
          lbm_pkg::ADDR_CLEAR_LEVEL: st_next.clear_level = st_reg.w_data;
          lbm_pkg::ADDR_LEAK_RATE: st_next.leak_rate = st_reg.w_data[1:0];
          lbm_pkg::ADDR_BUCKET_SIZE: st_next.bucket_size = st_reg.w_data;
          lbm_pkg::ADDR_IRQ_STATUS: st_next.irq_status = st_reg.irq_status & ~st_reg.w_data[1:0];
          lbm_pkg::ADDR_IRQ_MASK: st_next.irq_mask = st_reg.w_data[1:0];
          default: st_next.irq_mask = st_next.irq_mask;
        endcase
      end
    end
    // An event in the same cycle as its write-one-to-clear stays set.
    st_next.irq_status = st_next.irq_status | ev;
    st_next.irq = |(st_next.irq_status & st_next.irq_mask);
    st_next.awready = !st_next.aw_have && !st_next.bvalid;
    st_next.wready = !st_next.w_have && !st_next.bvalid;
    // Read channel: one read at a time, answered the cycle after the address is taken.
    if (st_reg.rvalid && s_axi_rready)
    begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_reg.arready)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp = lbm_mapped(s_axi_araddr[7:0]) ? lbm_pkg::RESP_OKAY : lbm_pkg::RESP_SLVERR;
      st_next.rdata = 32'h0000_0000;
      case (s_axi_araddr[7:0])
        lbm_pkg::ADDR_RAISE_LEVEL: st_next.rdata[7:0] = st_reg.raise_level;
        lbm_pkg::ADDR_CLEAR_LEVEL: st_next.rdata[7:0] = st_reg.clear_level;
        lbm_pkg::ADDR_LEAK_RATE: st_next.rdata[1:0] = st_reg.leak_rate;
        lbm_pkg::ADDR_BUCKET_SIZE: st_next.rdata[7:0] = st_reg.bucket_size;
        lbm_pkg::ADDR_STATUS:
        begin
          st_next.rdata[7:0] = st_reg.acc;
          st_next.rdata[lbm_pkg::STATUS_ALARM_BIT] = st_reg.alarm;
        end
        lbm_pkg::ADDR_IRQ_STATUS: st_next.rdata[1:0] = st_reg.irq_status;
        lbm_pkg::ADDR_IRQ_MASK: st_next.rdata[1:0] = st_reg.irq_mask;
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
    st_next.arready = !st_next.rvalid;
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg <= '0;
      st_reg.raise_level <= lbm_pkg::RAISE_LEVEL_RST;
      st_reg.clear_level <= lbm_pkg::CLEAR_LEVEL_RST;
      st_reg.leak_rate <= lbm_pkg::LEAK_RATE_RST;
      st_reg.bucket_size <= lbm_pkg::BUCKET_SIZE_RST;
      st_reg.irq_mask <= lbm_pkg::IRQ_MASK_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // All outputs come straight from the state register.
  assign alarm = st_reg.alarm;
  assign irq = st_reg.irq;
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the bucket and alarm behaviour and on the clear level reset value.
  property p_bad_adds;
    @(posedge aclk) disable iff (!aresetn)
    mon_tick && ref_bad && st_reg.acc < st_reg.bucket_size |=> st_reg.acc == $past(st_reg.acc) + 8'h01;
  endproperty
  a_bad_adds: assert property (p_bad_adds) else $error("bad cycle did not add one");

  property p_clean_leaks;
    @(posedge aclk) disable iff (!aresetn)
    mon_tick && !ref_bad && st_reg.acc != 8'h00 &&
      st_reg.leak_cnt + 4'h1 >= lbm_period(st_reg.leak_rate)
      |=> st_reg.acc == $past(st_reg.acc) - 8'h01;
  endproperty
  a_clean_leaks: assert property (p_clean_leaks) else $error("leak period did not subtract");

  property p_raise;
    @(posedge aclk) disable iff (!aresetn)
    !st_reg.alarm && st_reg.acc >= st_reg.raise_level |=> alarm ##1 irq || !st_reg.irq_mask[0];
  endproperty
  a_raise: assert property (p_raise) else $error("alarm not raised at raise level");

  property p_clear;
    @(posedge aclk) disable iff (!aresetn)
    st_reg.alarm && st_reg.acc <= st_reg.clear_level && st_reg.acc < st_reg.raise_level
      |=> !alarm && st_reg.irq_status[1];
  endproperty
  a_clear: assert property (p_clear) else $error("alarm not cleared at clear level");

  property p_clear_rst;
    @(posedge aclk)
    !aresetn |=> st_reg.clear_level == lbm_pkg::CLEAR_LEVEL_RST;
  endproperty
  a_clear_rst: assert property (p_clear_rst) else $error("clear level reset value wrong");

endmodule

// file: sim/leaky_bucket_activity_monitor_bench.sv
`timescale 1ns/1ns
module leaky_bucket_activity_monitor_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic mon_tick = 1'b0;
  logic ref_bad = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic alarm, irq, awready, wready, bvalid, arready, rvalid;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  int err_count = 0;
  int total_checks = 0;
  // Reset table: register address beside the value a read must return.
  logic [7:0] row_addr [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
  logic [31:0] row_data [6] = '{32'h0000_0008, 32'h0000_0004, 32'h0000_0001,
    32'h0000_0008, 32'h0000_0000, 32'h0000_0000};

  always #20 aclk = ~aclk;

  lbm_top lbm_top_i (.aclk(aclk), .aresetn(aresetn), .mon_tick(mon_tick), .ref_bad(ref_bad),
    .alarm(alarm), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, comparison and bus tasks.
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Handshakes are judged at the falling edge, where the registered readies are settled.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t, done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++)
    begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      done = bvalid;
      @(posedge aclk);
      if (aw_t)
        awvalid <= 1'b0;
      if (w_t)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!done)
      check(32'h0000_0000, 32'h0000_0001, "write timeout");
    if (!done)
      final_report();
    check({30'h0, bresp}, {30'h0, er}, "write response");
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_t, done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++)
    begin
      @(negedge aclk);
      ar_t = arvalid && arready;
      done = rvalid;
      @(posedge aclk);
      if (ar_t)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!done)
      check(32'h0000_0000, 32'h0000_0001, "read timeout");
    if (!done)
      final_report();
    check(rdata, ed, "read data");
    check({30'h0, rresp}, {30'h0, er}, "read response");
  endtask

  // One monitoring strobe per two clocks, then settling time for the alarm lag.
  task automatic tick(input logic bad, input int count);
    repeat (count)
    begin
      @(posedge aclk);
      mon_tick <= 1'b1;
      ref_bad <= bad;
      @(posedge aclk);
      mon_tick <= 1'b0;
    end
    repeat (3) @(posedge aclk);
  endtask

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 6; i++)
      axi_read(row_addr[i], row_data[i], 2'h0);
    check({30'h0, alarm, irq}, 32'h0000_0000, "outputs after reset");
    $display("Test reset defaults done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; the short thresholds keep every count small.
  initial
  begin
    do_reset();
    axi_write(8'h04, 32'h0000_015A, 2'h0);
    axi_read(8'h04, 32'h0000_005A, 2'h0);
    // A write with the low byte lane disabled must leave the register alone.
    wstrb <= 4'hE;
    axi_write(8'h04, 32'h0000_0022, 2'h0);
    wstrb <= 4'hF;
    axi_read(8'h04, 32'h0000_005A, 2'h0);
    axi_write(8'h00, 32'h0000_0003, 2'h0);
    axi_write(8'h04, 32'h0000_0001, 2'h0);
    axi_write(8'h08, 32'h0000_0000, 2'h0);
    axi_write(8'h18, 32'h0000_0001, 2'h0);
    tick(1'b1, 2);
    axi_read(8'h10, 32'h0000_0002, 2'h0);
    check({31'h0, alarm}, 32'h0000_0000, "alarm below raise level");
    tick(1'b1, 1);
    axi_read(8'h10, 32'h0000_0103, 2'h0);
    check({30'h0, alarm, irq}, 32'h0000_0003, "alarm and irq raised");
    tick(1'b0, 1);
    axi_read(8'h10, 32'h0000_0102, 2'h0);
    tick(1'b0, 1);
    axi_read(8'h10, 32'h0000_0001, 2'h0);
    axi_read(8'h14, 32'h0000_0003, 2'h0);
    axi_write(8'h14, 32'h0000_0001, 2'h0);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h0000_0000, "irq with clear event masked");
    axi_read(8'h14, 32'h0000_0002, 2'h0);
    // Unmasking the clear event must raise the interrupt, and clearing its status must drop it.
    axi_write(8'h18, 32'h0000_0002, 2'h0);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h0000_0001, "irq from clear event");
    axi_write(8'h14, 32'h0000_0002, 2'h0);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h0000_0000, "irq after clear event cleared");
    $display("Test alarm and interrupt done");
    // Leak periods 2, 4 and 8: one short of each keeps the count, the full period leaks one.
    for (int r = 1; r < 4; r++)
    begin
      axi_write(8'h08, r, 2'h0);
      tick(1'b1, 1);
      tick(1'b0, (1 << r) - 1);
      axi_read(8'h10, 32'h0000_0002, 2'h0);
      tick(1'b0, 1);
      axi_read(8'h10, 32'h0000_0001, 2'h0);
    end
    $display("Test leak periods done");
    // The count stops at the bucket size and never leaks below zero.
    axi_write(8'h0C, 32'h0000_0002, 2'h0);
    tick(1'b1, 3);
    axi_read(8'h10, 32'h0000_0002, 2'h0);
    axi_write(8'h08, 32'h0000_0000, 2'h0);
    tick(1'b0, 4);
    axi_read(8'h10, 32'h0000_0000, 2'h0);
    $display("Test bucket limits done");
    axi_write(8'h40, 32'h0000_0001, 2'h2);
    axi_read(8'h40, 32'h0000_0000, 2'h2);
    $display("Test unmapped address done");
    axi_write(8'h04, 32'h0000_0009, 2'h0);
    do_reset();
    final_report();
  end
endmodule
